// ===== logic/mct_pkg.sv
package mct_pkg;

  // ***************************************************************
  // Register indexes (byte address is four times the index)
  // ***************************************************************
  localparam logic [15:0] IDX_PRIO = 16'h103c;
  localparam logic [15:0] IDX_WDOG = 16'h103d;
  localparam logic [15:0] IDX_TEST = 16'h103e;
  localparam logic [15:0] IDX_BOOT = 16'h103f;

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int TB_ILLOP = 7;
  localparam int TB_PWM   = 6;
  localparam int TB_FLAGS = 5;
  localparam int TB_COUNTER1_BYPASS_BIT = 4;
  localparam int TB_RESET_DISABLE_BIT  = 3;
  localparam int TB_FCM   = 2;
  localparam int TB_FORCE_WATCHDOG_BIT  = 1;
  localparam int TB_COUNTER2_BYPASS_BIT = 0;
  localparam int PB_SPECIAL_MODE_BIT  = 6;
  localparam int PB_MDA   = 5;
  localparam int CB_CME   = 1;
  localparam int CB_WATCHDOG_DISABLE_BIT = 0;
  localparam logic [7:0] TEST_RST = 8'h00;

  // ***************************************************************
  // Vector map
  // ***************************************************************
  localparam logic [15:0] VEC_BOOT_BASE  = 16'h00b5;
  localparam logic [15:0] VEC_BOOT_STEP  = 16'h0003;
  localparam logic [15:0] VEC_BOOT_RESET = 16'hbf40;
  localparam logic [15:0] VEC_TEST       = 16'hbffe;
  localparam logic [15:0] VEC_NORM_BASE  = 16'hffce;
  localparam logic [15:0] VEC_NORM_STEP  = 16'h0002;
  localparam logic [15:0] VEC_NORM_RESET = 16'hfffe;
  localparam logic [4:0]  VEC_SRC_RESET  = 5'h1f;
  localparam logic [15:0] RAM_JUMP       = 16'h0000;

  // ***************************************************************
  // Loader timing in bus clocks
  // ***************************************************************
  localparam logic [6:0]  BIT_FAST    = 7'h10;
  localparam logic [6:0]  BIT_SLOW    = 7'h68;
  localparam logic [12:0] MEAS_THRESH = 13'h003c;
  localparam logic [12:0] IDLE_FAST   = 13'h0280;
  localparam logic [12:0] IDLE_SLOW   = 13'h1040;

  typedef enum logic [7:0] {
    BS_OFF   = 8'h01,
    BS_BRK   = 8'h02,
    BS_MEAS  = 8'h04,
    BS_IDLE  = 8'h08,
    BS_START = 8'h10,
    BS_DATA  = 8'h20,
    BS_STOP  = 8'h40,
    BS_DONE  = 8'h80
  } mct_boot_t;

  typedef struct packed {
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [7:0]  pc_sync1;
    logic        special_mode_bit;
    logic        mode_a_select_bit;
    logic [7:0]  test;
    logic        clock_monitor_enable_bit;
    logic        watchdog_disable_bit;
    logic        wd_rst;
    logic        cm_rst;
    logic        wr_pend;
    logic        hit;
    logic [15:0] idx;
    logic [31:0] hrdata;
    logic        rdy;
    logic [7:0]  port_b;
    logic [7:0]  port_f;
    logic [7:0]  port_c_out;
    logic        port_c_oe_n;
    logic        rw_n;
    logic [7:0]  ext_rdata;
    logic [15:0] vec_addr;
    logic        vec_ext;
    logic        vec_valid;
    logic        lir_n;
    logic        ill_trap;
    logic [7:0]  pwm_rd;
    logic [7:0]  timer_port;
    logic        counter1_bypass_bit;
    logic        counter2_bypass_bit;
    mct_boot_t   st;
    logic        armed;
    logic        rate104;
    logic [6:0]  bitlen;
    logic [12:0] cnt;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic [8:0]  wptr;
    logic [8:0]  ram_addr;
    logic [7:0]  ram_wdata;
    logic        ram_we;
    logic        tx;
    logic        jump;
  } mct_state_t;

endpackage

// ===== logic/mct_top.sv
// The implementer's own choice: the AHB-Lite register port.
module mct_top
  import mct_pkg::*;
#(
  parameter logic [12:0] BOOT_IDLE_SLOW = mct_pkg::IDLE_SLOW
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Mode pins
  input  wire logic        mode_pin_a,
  input  wire logic        mode_pin_b,
  // Core external bus request
  input  wire logic [15:0] core_addr,
  input  wire logic [7:0]  core_wdata,
  input  wire logic        core_rd,
  input  wire logic        core_wr,
  output logic [7:0]       ext_rdata,
  // External bus pins
  output logic [7:0]       port_b,
  output logic [7:0]       port_f,
  output logic [7:0]       port_c_out,
  output logic             port_c_oe_n,
  input  wire logic [7:0]  port_c_in,
  output logic             rw_n,
  // Vector fetch
  input  wire logic        vec_req,
  input  wire logic [4:0]  vec_src,
  output logic [15:0]      vec_addr,
  output logic             vec_ext,
  output logic             vec_valid,
  // Serial loader
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             ram_we,
  output logic [8:0]       ram_addr,
  output logic [7:0]       ram_wdata,
  output logic             boot_jump,
  // Core test hooks
  input  wire logic        instr_start,
  input  wire logic        illegal_op,
  output logic             load_instruction_indicator_n,
  output logic             illegal_trap,
  input  wire logic        pwm_scaled_clk,
  input  wire logic [7:0]  pwm_scaler_reg,
  output logic [7:0]       pwm_scaler_rd,
  input  wire logic [4:0]  ccr_flags,
  input  wire logic [7:0]  timer_port_func,
  output logic [7:0]       timer_port,
  output logic             counter1_split,
  output logic             counter2_split,
  // Reset sources
  input  wire logic        wd_timeout,
  input  wire logic        cm_fail,
  output logic             wd_reset,
  output logic             cm_reset
);

  mct_state_t s_q;
  mct_state_t s_d;
  logic [7:0] te;
  logic       rx;
  logic [12:0] idle_lim;
  logic       take;

  assign te       = s_q.special_mode_bit ? s_q.test : 8'h00;
  assign rx       = s_q.sync2[2];
  assign idle_lim = s_q.rate104 ? BOOT_IDLE_SLOW : IDLE_FAST;
  assign take     = hsel && htrans[1] && hready;

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    s_d = s_q;
    s_d.ram_we = 1'b0;
    s_d.jump = 1'b0;
    s_d.vec_valid = 1'b0;
    s_d.rdy = 1'b1;

    // Register writes land in the data phase
    if (s_q.wr_pend && s_q.hit) begin
      case (s_q.idx)
        IDX_PRIO: begin
          s_d.special_mode_bit = s_q.special_mode_bit & hwdata[PB_SPECIAL_MODE_BIT];
          if (s_q.special_mode_bit) begin
            s_d.mode_a_select_bit = hwdata[PB_MDA];
          end
        end
        IDX_TEST: begin
          if (s_q.special_mode_bit) begin
            s_d.test = hwdata[7:0];
          end
        end
        IDX_WDOG: begin
          if (s_q.special_mode_bit) begin
            s_d.clock_monitor_enable_bit = hwdata[CB_CME];
            s_d.watchdog_disable_bit = hwdata[CB_WATCHDOG_DISABLE_BIT];
          end
        end
        default: ;
      endcase
    end
    s_d.wr_pend = 1'b0;
    if (take) begin
      s_d.wr_pend = hwrite;
      s_d.hit = (haddr[31:18] == 14'h0000);
      s_d.idx = haddr[17:2];
    end
    // Read data is built from the updated copy so a write then read sees new data
    if (take && !hwrite) begin
      s_d.hrdata = 32'h0000_0000;
      if (haddr[31:18] == 14'h0000) begin
        case (haddr[17:2])
          IDX_PRIO: begin
            s_d.hrdata[PB_SPECIAL_MODE_BIT] = s_d.special_mode_bit;
            s_d.hrdata[PB_MDA] = s_d.mode_a_select_bit;
          end
          IDX_TEST: s_d.hrdata[7:0] = s_d.special_mode_bit ? s_d.test : 8'h00;
          IDX_WDOG: begin
            s_d.hrdata[CB_CME] = s_d.clock_monitor_enable_bit;
            s_d.hrdata[CB_WATCHDOG_DISABLE_BIT] = s_d.watchdog_disable_bit;
          end
          IDX_BOOT: s_d.hrdata[26:0] = {s_q.wptr, s_q.rate104, s_q.st, s_q.ram_addr};
          default: ;
        endcase
      end
    end

    // External bus
    s_d.ext_rdata = s_q.pc_sync1;
    if (s_q.mode_a_select_bit) begin
      s_d.port_b = core_addr[15:8];
      s_d.port_f = core_addr[7:0];
      s_d.port_c_out = core_wdata;
      s_d.port_c_oe_n = !core_wr;
      s_d.rw_n = !core_wr;
    end else begin
      s_d.port_b = 8'h00;
      s_d.port_f = 8'h00;
      s_d.port_c_out = 8'h00;
      s_d.port_c_oe_n = 1'b1;
      s_d.rw_n = 1'b1;
    end

    // Vector addressing
    if (vec_req) begin
      s_d.vec_valid = 1'b1;
      s_d.vec_ext = s_q.special_mode_bit && s_q.mode_a_select_bit;
      case ({s_q.special_mode_bit, s_q.mode_a_select_bit})
        2'b10: s_d.vec_addr = (vec_src == VEC_SRC_RESET) ? VEC_BOOT_RESET
                 : VEC_BOOT_BASE + {11'h000, vec_src} * VEC_BOOT_STEP;
        2'b11: s_d.vec_addr = VEC_TEST;
        default: s_d.vec_addr = (vec_src == VEC_SRC_RESET) ? VEC_NORM_RESET
                 : VEC_NORM_BASE + {11'h000, vec_src} * VEC_NORM_STEP;
      endcase
    end

    // Test hooks
    s_d.lir_n = !(instr_start && !(illegal_op && te[TB_ILLOP]));
    s_d.ill_trap = instr_start && illegal_op && !te[TB_ILLOP];
    s_d.pwm_rd = te[TB_PWM] ? {pwm_scaler_reg[7:1], pwm_scaled_clk} : pwm_scaler_reg;
    s_d.timer_port = te[TB_FLAGS] ? {ccr_flags[0], ccr_flags[1], ccr_flags[2], ccr_flags[3],
                                     ccr_flags[4], timer_port_func[2:0]}
                                  : timer_port_func;
    s_d.counter1_bypass_bit = te[TB_COUNTER1_BYPASS_BIT];
    s_d.counter2_bypass_bit = te[TB_COUNTER2_BYPASS_BIT];

    // Reset requests; the disable bit wins over everything
    s_d.wd_rst = !te[TB_RESET_DISABLE_BIT] && !s_q.watchdog_disable_bit && (te[TB_FORCE_WATCHDOG_BIT] || wd_timeout);
    s_d.cm_rst = !te[TB_RESET_DISABLE_BIT] && s_q.clock_monitor_enable_bit && (te[TB_FCM] || cm_fail);

    // Serial loader
    case (s_q.st)
      BS_OFF: begin
        if (s_q.armed) begin
          s_d.armed = 1'b0;
          if (s_q.special_mode_bit && !s_q.mode_a_select_bit) begin
            s_d.st = BS_BRK;
          end
        end
      end
      BS_BRK: begin
        s_d.tx = 1'b0;
        if (!rx) begin
          s_d.st = BS_MEAS;
          s_d.cnt = 13'h0001;
          s_d.tx = 1'b1;
        end
      end
      BS_MEAS: begin
        // Start bit length tells the rate; the byte itself is swallowed
        if (!rx) begin
          if (s_q.cnt != 13'h1fff) begin
            s_d.cnt = s_q.cnt + 13'h0001;
          end
        end else begin
          s_d.rate104 = (s_q.cnt > MEAS_THRESH);
          s_d.bitlen = (s_q.cnt > MEAS_THRESH) ? BIT_SLOW : BIT_FAST;
          s_d.st = BS_IDLE;
          s_d.cnt = 13'h0000;
        end
      end
      BS_IDLE: begin
        if (!rx) begin
          s_d.st = BS_START;
          s_d.cnt = 13'h0000;
        end else if (s_q.cnt >= idle_lim - 13'h0001) begin
          s_d.jump = 1'b1;
          s_d.st = BS_DONE;
        end else begin
          s_d.cnt = s_q.cnt + 13'h0001;
        end
      end
      BS_START: begin
        if (s_q.cnt == {7'h00, s_q.bitlen[6:1]}) begin
          s_d.cnt = 13'h0000;
          s_d.bitn = 4'h0;
          s_d.st = rx ? BS_IDLE : BS_DATA;
        end else begin
          s_d.cnt = s_q.cnt + 13'h0001;
        end
      end
      BS_DATA: begin
        if (s_q.cnt == {6'h00, s_q.bitlen} - 13'h0001) begin
          s_d.cnt = 13'h0000;
          s_d.shreg = {rx, s_q.shreg[7:1]};
          s_d.bitn = s_q.bitn + 4'h1;
          if (s_q.bitn == 4'h7) begin
            s_d.st = BS_STOP;
          end
        end else begin
          s_d.cnt = s_q.cnt + 13'h0001;
        end
      end
      BS_STOP: begin
        if (s_q.cnt == {6'h00, s_q.bitlen} - 13'h0001) begin
          s_d.cnt = 13'h0000;
          s_d.st = BS_IDLE;
          // Framing errors drop the byte rather than corrupt RAM order
          if (rx) begin
            s_d.ram_we = 1'b1;
            s_d.ram_addr = s_q.wptr;
            s_d.ram_wdata = s_q.shreg;
            s_d.wptr = s_q.wptr + 9'h001;
          end
        end else begin
          s_d.cnt = s_q.cnt + 13'h0001;
        end
      end
      BS_DONE: s_d.st = BS_DONE;
      default: s_d.st = BS_OFF;
    endcase

    // Synchronous reset; pins were synchronised while reset was held
    if (!rstn) begin
      s_d = '0;
      s_d.special_mode_bit = !s_q.sync2[1];
      s_d.mode_a_select_bit = s_q.sync2[0];
      s_d.test = TEST_RST;
      s_d.test[TB_RESET_DISABLE_BIT] = !s_q.sync2[1];
      s_d.rdy = 1'b1;
      s_d.port_c_oe_n = 1'b1;
      s_d.rw_n = 1'b1;
      s_d.lir_n = 1'b1;
      s_d.tx = 1'b1;
      s_d.st = BS_OFF;
      s_d.armed = 1'b1;
      s_d.bitlen = BIT_FAST;
    end
    s_d.sync1 = {rx_pin, mode_pin_b, mode_pin_a};
    s_d.sync2 = s_q.sync1;
    s_d.pc_sync1 = port_c_in;
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign hreadyout = s_q.rdy;
  assign hrdata = s_q.hrdata;
  assign hresp = 1'b0;
  assign ext_rdata = s_q.ext_rdata;
  assign port_b = s_q.port_b;
  assign port_f = s_q.port_f;
  assign port_c_out = s_q.port_c_out;
  assign port_c_oe_n = s_q.port_c_oe_n;
  assign rw_n = s_q.rw_n;
  assign vec_addr = s_q.vec_addr;
  assign vec_ext = s_q.vec_ext;
  assign vec_valid = s_q.vec_valid;
  assign tx_pin = s_q.tx;
  assign ram_we = s_q.ram_we;
  assign ram_addr = s_q.ram_addr;
  assign ram_wdata = s_q.ram_wdata;
  assign boot_jump = s_q.jump;
  assign load_instruction_indicator_n = s_q.lir_n;
  assign illegal_trap = s_q.ill_trap;
  assign pwm_scaler_rd = s_q.pwm_rd;
  assign timer_port = s_q.timer_port;
  assign counter1_split = s_q.counter1_bypass_bit;
  assign counter2_split = s_q.counter2_bypass_bit;
  assign wd_reset = s_q.wd_rst;
  assign cm_reset = s_q.cm_rst;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_single_rw;
    !s_q.mode_a_select_bit |=> rw_n && port_c_oe_n;
  endproperty
  a_single_rw: assert property (p_single_rw) else $error("read level lost");

  property p_exp_addr;
    s_q.mode_a_select_bit && core_wr |=> port_b == $past(core_addr[15:8]) && port_f == $past(core_addr[7:0])
                           && !rw_n && !port_c_oe_n;
  endproperty
  a_exp_addr: assert property (p_exp_addr) else $error("expanded bus wrong");

  property p_jump_idle;
    boot_jump |-> $past(rx, 1) && $past(rx, 2) && $past(s_q.st) == BS_IDLE;
  endproperty
  a_jump_idle: assert property (p_jump_idle) else $error("jump without idle");

  property p_break;
    s_q.st == BS_BRK && rx |=> !tx_pin;
  endproperty
  a_break: assert property (p_break) else $error("no break");

  property p_no_echo;
    s_q.st == BS_MEAS |-> tx_pin ##1 tx_pin[*8];
  endproperty
  a_no_echo: assert property (p_no_echo) else $error("echo seen");

  property p_boot_vec;
    vec_req && s_q.special_mode_bit && !s_q.mode_a_select_bit && vec_src != VEC_SRC_RESET
      |=> vec_valid && vec_addr == 16'h00b5 + 16'h0003 * {11'h000, $past(vec_src)};
  endproperty
  a_boot_vec: assert property (p_boot_vec) else $error("pseudo-vector wrong");

  property p_test_vec;
    vec_req && s_q.special_mode_bit && s_q.mode_a_select_bit |=> vec_ext && vec_addr == 16'hbffe;
  endproperty
  a_test_vec: assert property (p_test_vec) else $error("test vector wrong");

  property p_special_mode_bit_sticky;
    !s_q.special_mode_bit |=> !s_q.special_mode_bit;
  endproperty
  a_special_mode_bit_sticky: assert property (p_special_mode_bit_sticky) else $error("special bit set again");

  property p_test_zero;
    take && !hwrite && haddr == 32'h0000_40f8 && !s_q.special_mode_bit ##1 !s_q.special_mode_bit |-> hrdata == 32'h0;
  endproperty
  a_test_zero: assert property (p_test_zero) else $error("test register not zero");

  property p_illop;
    instr_start && illegal_op && s_q.special_mode_bit && s_q.test[TB_ILLOP]
      |=> load_instruction_indicator_n && !illegal_trap;
  endproperty
  a_illop: assert property (p_illop) else $error("illegal opcode trapped");

  property p_flags;
    s_q.special_mode_bit && s_q.test[TB_FLAGS] |=> timer_port[7:3] == {$past(ccr_flags[0]),
      $past(ccr_flags[1]), $past(ccr_flags[2]), $past(ccr_flags[3]), $past(ccr_flags[4])};
  endproperty
  a_flags: assert property (p_flags) else $error("flag output wrong");

  property p_reset_disable_bit;
    s_q.special_mode_bit && s_q.test[TB_RESET_DISABLE_BIT] |=> !wd_reset && !cm_reset;
  endproperty
  a_reset_disable_bit: assert property (p_reset_disable_bit) else $error("reset not blocked");

  property p_fcm;
    s_q.special_mode_bit && s_q.test[TB_FCM] && !s_q.test[TB_RESET_DISABLE_BIT] && s_q.clock_monitor_enable_bit |=> cm_reset;
  endproperty
  a_fcm: assert property (p_fcm) else $error("forced monitor reset missing");

  property p_force_watchdog_bit;
    s_q.special_mode_bit && s_q.test[TB_FORCE_WATCHDOG_BIT] && !s_q.test[TB_RESET_DISABLE_BIT] |=> wd_reset == !$past(s_q.watchdog_disable_bit);
  endproperty
  a_force_watchdog_bit: assert property (p_force_watchdog_bit) else $error("forced watchdog reset wrong");

endmodule

// ===== verif/mct_serial_host.sv
module mct_serial_host (
  // Clock
  input  wire logic clk,
  // Line into the device receiver
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************
  // Frame sender
  // ************************************************
  // Idles high between frames so no false start bit
  initial rx_line = 1'b1;

  // Start bit, eight data bits LSB first, stop bit
  task automatic send(input logic [7:0] b, input int bl);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rx_line <= fr[i];
      repeat (bl - 1) @(posedge clk);
    end
  endtask
endmodule

// ===== verif/mode_control_test_register_tb_top.sv
module mode_control_test_register_tb_top;
  import mct_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************
  // Signals
  // ************************************************
  localparam int          LIMIT     = 20000;
  localparam logic [12:0] SLOW_IDLE = IDLE_SLOW;
  logic        clk, rstn, hwrite, hreadyout, hresp, mpa, mpb;
  logic        core_rd, core_wr, vec_req, vec_ext, vec_valid, rx_pin, tx_pin;
  logic        ram_we, boot_jump, instr_start, illegal_op, lir_n, illegal_trap;
  logic        pwm_scaled_clk, c1s, c2s, wd_timeout, wd_reset, cm_reset, rw_n, oe_n, cm_fail;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r, seed;
  logic [15:0] core_addr, vec_addr;
  logic [7:0]  core_wdata, ext_rdata, port_b, port_f, port_c_out, ext_drive, ram_wdata;
  logic [7:0]  pwm_scaler_reg, pwm_scaler_rd, timer_port_func, timer_port, tv, dt;
  wire  [7:0]  port_c_in;
  logic [4:0]  vec_src, ccr_flags, s;
  logic [8:0]  ram_addr;
  logic [8:0]  wa[$];
  logic [7:0]  wd[$];
  logic [7:0]  by[2];
  int          err_count, total_checks, cyc, jumps, tx_low, n, bl, il;
  bit          tx_watch;

  // Wire level of the shared data pins from both parties
  assign port_c_in = oe_n ? ext_drive : port_c_out;

  mct_top #(.BOOT_IDLE_SLOW(SLOW_IDLE)) dut (
    .clk(clk), .rstn(rstn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .mode_pin_a(mpa), .mode_pin_b(mpb), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_rd(core_rd), .core_wr(core_wr),
    .ext_rdata(ext_rdata), .port_b(port_b), .port_f(port_f),
    .port_c_out(port_c_out), .port_c_oe_n(oe_n), .port_c_in(port_c_in),
    .rw_n(rw_n), .vec_req(vec_req), .vec_src(vec_src), .vec_addr(vec_addr),
    .vec_ext(vec_ext), .vec_valid(vec_valid), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .boot_jump(boot_jump), .instr_start(instr_start), .illegal_op(illegal_op),
    .load_instruction_indicator_n(lir_n), .illegal_trap(illegal_trap),
    .pwm_scaled_clk(pwm_scaled_clk), .pwm_scaler_reg(pwm_scaler_reg),
    .pwm_scaler_rd(pwm_scaler_rd), .ccr_flags(ccr_flags),
    .timer_port_func(timer_port_func), .timer_port(timer_port),
    .counter1_split(c1s), .counter2_split(c2s), .wd_timeout(wd_timeout),
    .cm_fail(cm_fail), .wd_reset(wd_reset), .cm_reset(cm_reset)
  );

  mct_serial_host host (.clk(clk), .rx_line(rx_pin));

  // ************************************************
  // Helpers
  // ************************************************
  always #50 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] exp_vec(input logic a, input logic b, input logic [4:0] v);
    if (!b && a) return VEC_TEST;
    if (!b) return (v == VEC_SRC_RESET) ? VEC_BOOT_RESET : VEC_BOOT_BASE + VEC_BOOT_STEP * 16'(v);
    return (v == VEC_SRC_RESET) ? VEC_NORM_RESET : VEC_NORM_BASE + VEC_NORM_STEP * 16'(v);
  endfunction

  function automatic logic [7:0] exp_tport(input logic on, input logic [4:0] f, input logic [7:0] p);
    return on ? {f[0], f[1], f[2], f[3], f[4], p[2:0]} : p;
  endfunction

  task automatic results();
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Single word transfer; waits on the slave, never on a cycle count
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, r & m, e);
    chk("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic rst(input logic a, input logic b);
    @(posedge clk);
    rstn <= 1'b0;
    mpa  <= a;
    mpb  <= b;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    wa.delete();
    wd.delete();
    jumps = 0;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (ram_we === 1'b1) begin
      wa.push_back(ram_addr);
      wd.push_back(ram_wdata);
    end
    if (boot_jump === 1'b1) jumps++;
    if (tx_watch && tx_pin === 1'b0) tx_low++;
    if (cyc == LIMIT) begin
      err_count++;
      results();
    end
  end

  // ************************************************
  // Sequence
  // ************************************************
  initial begin
    {clk, rstn, hwrite, mpa, mpb, core_rd, core_wr, vec_req} = '0;
    {instr_start, illegal_op, pwm_scaled_clk, wd_timeout, cm_fail, tx_watch} = '0;
    {htrans, haddr, hwdata, core_addr, core_wdata, ext_drive, vec_src} = '0;
    {ccr_flags, pwm_scaler_reg, timer_port_func} = '0;
    seed = 32'h0000fe23;
    for (int m = 0; m < 4; m++) begin
      rst(m[0], m[1]);
      rdchk("prio", 32'h40f0, 32'h60, {25'h0, !mpb, mpa, 5'h0});
      rdchk("test_rst", 32'h40f8, 32'hff, mpb ? 32'h0 : 32'h8);
      core_addr <= 16'(rnd());
      ext_drive <= 8'(rnd());
      core_rd   <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("port_b", 32'(port_b), mpa ? 32'(core_addr[15:8]) : 32'h0);
      chk("port_f", 32'(port_f), mpa ? 32'(core_addr[7:0]) : 32'h0);
      chk("rw_rd", 32'(rw_n), 32'h1);
      if (mpa) chk("ext_rdata", 32'(ext_rdata), 32'(ext_drive));
      dt = 8'(rnd());
      @(posedge clk);
      core_rd    <= 1'b0;
      core_wr    <= 1'b1;
      core_wdata <= dt;
      repeat (2) @(posedge clk);
      #1 chk("rw_wr", 32'(rw_n), 32'(!mpa));
      chk("oe_n", 32'(oe_n), 32'(!mpa));
      if (mpa) chk("port_c", 32'(port_c_out), 32'(dt));
      @(posedge clk);
      core_wr <= 1'b0;
      for (int k = 0; k < 2; k++) begin
        s = k ? VEC_SRC_RESET : 5'(rnd() % 25);
        @(posedge clk);
        vec_req <= 1'b1;
        vec_src <= s;
        @(posedge clk);
        vec_req <= 1'b0;
        #1 chk("vec", 32'(vec_addr), 32'(exp_vec(mpa, mpb, s)));
        chk("vvalid", 32'(vec_valid), 32'h1);
        chk("vext", 32'(vec_ext), 32'(mpa && !mpb));
      end
    end
    // Force bits against enables and the disable bit
    rst(1'b1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      tv = (i == 0) ? 8'h0e : 8'h06;
      bus(1'b1, 32'h40f4, (i == 2) ? 32'h1 : 32'h2);
      bus(1'b1, 32'h40f8, 32'(tv));
      rdchk("test_rw", 32'h40f8, 32'hff, 32'(tv));
      #1 chk("wd_rst", 32'(wd_reset), 32'(i == 1));
      chk("cm_rst", 32'(cm_reset), 32'(i == 1));
    end
    // Live timeouts pass only while the disable bit is clear
    bus(1'b1, 32'h40f4, 32'h2);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 32'h40f8, i ? 32'h0 : 32'h8);
      wd_timeout <= 1'b1;
      cm_fail    <= 1'b1;
      repeat (3) @(posedge clk);
      wd_timeout <= 1'b0;
      cm_fail    <= 1'b0;
      #1 chk("wd_live", 32'(wd_reset), 32'(i));
      chk("cm_live", 32'(cm_reset), 32'(i));
    end
    // Test hooks on, then off
    for (int i = 0; i < 2; i++) begin
      tv = i ? 8'h00 : 8'hf1;
      bus(1'b1, 32'h40f8, 32'(tv));
      ccr_flags       <= 5'(rnd());
      timer_port_func <= 8'(rnd());
      pwm_scaler_reg  <= 8'(rnd());
      pwm_scaled_clk  <= 1'(rnd());
      instr_start     <= 1'b1;
      illegal_op      <= 1'b1;
      @(posedge clk);
      instr_start <= 1'b0;
      illegal_op  <= 1'b0;
      #1 chk("tport", 32'(timer_port), 32'(exp_tport(tv[5], ccr_flags, timer_port_func)));
      chk("pwm", 32'(pwm_scaler_rd), tv[6] ? 32'({pwm_scaler_reg[7:1], pwm_scaled_clk})
                                           : 32'(pwm_scaler_reg));
      chk("trap", 32'(illegal_trap), 32'(!tv[7]));
      chk("lir", 32'(lir_n), 32'(tv[7]));
      chk("split1", 32'(c1s), 32'(tv[4]));
      chk("split2", 32'(c2s), 32'(tv[0]));
    end
    // Leaving the special mode is one way until reset
    bus(1'b1, 32'h40f8, 32'h11);
    bus(1'b1, 32'h40f0, 32'h20);
    bus(1'b1, 32'h40f0, 32'h60);
    rdchk("special_mode_bit_lock", 32'h40f0, 32'h60, 32'h20);
    bus(1'b1, 32'h40f8, 32'hff);
    rdchk("test_off", 32'h40f8, 32'hff, 32'h0);
    #1 chk("split_off", 32'(c1s), 32'h0);
    rdchk("unmapped", 32'h4100, 32'hffffffff, 32'h0);
    // Loader at both host rates
    for (int k = 0; k < 2; k++) begin
      bl = k ? 104 : 16;
      il = k ? int'(IDLE_SLOW) : int'(IDLE_FAST);
      rst(1'b0, 1'b0);
      repeat (4) @(posedge clk);
      #1 chk("break", 32'(tx_pin), 32'h0);
      host.send(8'hff, bl);
      tx_low   = 0;
      tx_watch = 1'b1;
      rdchk("rate", 32'h40fc, 32'h20000, k ? 32'h20000 : 32'h0);
      for (int j = 0; j < 2; j++) begin
        by[j] = 8'(rnd());
        host.send(by[j], bl);
      end
      n = 0;
      while (jumps == 0 && n < 6000) begin
        @(posedge clk);
        n++;
      end
      chk("jump", 32'(n >= il - bl - 8 && n <= il + bl + 8), 32'h1);
      chk("nwr", 32'(wa.size()), 32'h2);
      chk("wa0", 32'(wa[0]), 32'h0);
      chk("wd0", 32'(wd[0]), 32'(by[0]));
      chk("wa1", 32'(wa[1]), 32'h1);
      chk("wd1", 32'(wd[1]), 32'(by[1]));
      chk("no_echo", 32'(tx_low), 32'h0);
      tx_watch = 1'b0;
    end
    results();
  end
endmodule
